// ### src/kpm_menu.sv
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module kpm_menu import kpm_pkg::*; #(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic key_mode,
  input wire logic key_next,
  input wire logic key_digit,
  input wire logic key_inc,
  input wire logic key_clear,
  input wire logic [31:0] first_rate_channel,
  input wire logic [31:0] second_rate_channel,
  input wire logic [31:0] derived_result,
  input wire logic input_activity,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  output logic prog_mode,
  output logic code_prompt,
  output logic dotted_line,
  output logic [7:0] disp_line,
  output logic [31:0] disp_value,
  output logic [7:0] digit_flash,
  output logic [1:0] op_select,
  output logic clear_param,
  output logic reading_zero,
  output logic rate_update,
  output logic update_tick,
  output logic retain_readings,
  output logic [2:0] func_sel,
  output logic swap_channels,
  output logic quad_decode,
  output logic second_slow,
  output logic input_sinking,
  output logic [1:0] input_level,
  output logic [31:0] first_scale,
  output logic [31:0] second_scale,
  output logic [31:0] result_scale,
  output logic [1:0] first_unit,
  output logic [1:0] second_unit,
  output logic [1:0] first_dp,
  output logic [1:0] second_dp
);
  kpm_state_e state_reg;
  logic [31:0] tick_cnt_reg;
  logic [6:0] tenth_cnt_reg;
  logic ms_tick, tenth_tick;
  logic [4:0] keys_raw, samp_reg, db_reg, db_d_reg, press;
  logic [3:0] hold_reg;
  logic rep_pulse, next_go;
  logic [3:0] idx_reg;
  logic [2:0] dpos_reg;
  logic [31:0] edit_reg;
  logic [9:0] tmo_reg;
  logic [1:0] stat_reg [3];
  logic [31:0] cfg_edit [NCFG];
  logic [31:0] cfg_live [NCFG];
  logic [15:0] code_reg;
  logic code_ok, in_field;
  logic [9:0] upd_reg, sst_reg;

  // common millisecond and tenth ticks
  // divided time tick
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_cnt_reg <= 32'h0000_0000;
      tenth_cnt_reg <= 7'h00;
    end else if (ms_tick) begin
      tick_cnt_reg <= 32'h0000_0000;
      tenth_cnt_reg <= tenth_tick ? 7'h00 : tenth_cnt_reg + 7'h01;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end
  assign ms_tick = (tick_cnt_reg == 32'(TICK_LEN - 1));
  assign tenth_tick = ms_tick && (tenth_cnt_reg == TICKS_PER_TENTH - 7'h01);

  // key debounce: a level must agree on two ms samples
  assign keys_raw = {key_clear, key_inc, key_digit, key_next, key_mode};
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      samp_reg <= 5'h00;
      db_reg <= 5'h00;
      db_d_reg <= 5'h00;
    end else begin
      db_d_reg <= db_reg;
      if (ms_tick) begin
        samp_reg <= keys_raw;
        db_reg <= (db_reg & (samp_reg | keys_raw)) | (samp_reg & keys_raw);
      end
    end
  end
  assign press = db_reg & ~db_d_reg;

  // auto-repeat of the next key while held in field three
  // next key repeat
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_reg <= 4'h0;
    end else if (!db_reg[K_NEXT] || state_reg != ST_F3) begin
      hold_reg <= 4'h0;
    end else if (tenth_tick && hold_reg != REP_DELAY_TENTHS) begin
      hold_reg <= hold_reg + 4'h1;
    end
  end
  assign rep_pulse = tenth_tick && (hold_reg == REP_DELAY_TENTHS)
                     && db_reg[K_NEXT] && (state_reg == ST_F3);
  assign next_go = press[K_NEXT] || rep_pulse;

  assign code_ok = (code_reg == CODE_RESET)
                   || (edit_reg[15:0] == code_reg);
  assign in_field = (state_reg == ST_F1) || (state_reg == ST_F1_END)
                    || (state_reg == ST_F2) || (state_reg == ST_F2_END)
                    || (state_reg == ST_F3) || (state_reg == ST_F3_END);

  // programming state machine with line and digit editing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_OPER;
      idx_reg <= 4'h0;
      dpos_reg <= 3'h0;
      edit_reg <= 32'h0000_0000;
      tmo_reg <= 10'h000;
      for (int i = 0; i < 3; i++) stat_reg[i] <= 2'h0;
      for (int i = 0; i < NCFG; i++) begin
        cfg_edit[i] <= cfg_default(4'(i));
        cfg_live[i] <= cfg_default(4'(i));
      end
    end else begin
      case (state_reg)
        ST_OPER: begin
          if (press[K_MODE]) begin
            state_reg <= ST_CODE;
            edit_reg <= 32'h0000_0000;
            dpos_reg <= 3'h0;
            tmo_reg <= 10'h000;
            for (int i = 0; i < NCFG; i++) cfg_edit[i] <= cfg_live[i];
          end
        end
        ST_CODE, ST_CODE_BAD: begin
          if (press[K_MODE]) begin
            state_reg <= ST_OPER;
          end else if (next_go) begin
            state_reg <= code_ok ? ST_F1 : ST_CODE_BAD;
            dpos_reg <= 3'h0;
            idx_reg <= 4'h0;
            tmo_reg <= 10'h000;
          end else begin
            if (press[K_DIGIT])
              dpos_reg <= (dpos_reg == CODE_DIGITS_LAST) ? 3'h0
                          : dpos_reg + 3'h1;
            if (press[K_INC])
              edit_reg <= bump(edit_reg, dpos_reg, 4'd9);
            if (state_reg == ST_CODE_BAD && tenth_tick) begin
              if (tmo_reg == CODE_TMO_TENTHS - 10'h001)
                state_reg <= ST_OPER;
              tmo_reg <= tmo_reg + 10'h001;
            end
          end
        end
        default: begin
          if (press[K_MODE]) begin
            state_reg <= ST_OPER;
            for (int i = 0; i < NCFG; i++)
              cfg_live[i] <= (is_scale(4'(i)) && cfg_edit[i] == 32'h0)
                             ? SCALE_MIN : cfg_edit[i];
          end else if (state_reg == ST_F3 && press[K_NEXT]
                       && db_reg[K_INC]) begin
            idx_reg <= (idx_reg == 4'h0) ? 4'h0 : idx_reg - 4'h1;
            dpos_reg <= 3'h0;
          end else if (next_go) begin
            dpos_reg <= 3'h0;
            case (state_reg)
              ST_F1: begin
                if (idx_reg == 4'h2) state_reg <= ST_F1_END;
                else idx_reg <= idx_reg + 4'h1;
              end
              ST_F1_END: begin
                state_reg <= ST_F2;
                idx_reg <= 4'h0;
                edit_reg <= {30'h0, stat_reg[0]};
              end
              ST_F2: begin
                stat_reg[idx_reg[1:0]] <= edit_reg[1:0];
                if (idx_reg == 4'h2) begin
                  state_reg <= ST_F2_END;
                end else begin
                  idx_reg <= idx_reg + 4'h1;
                  edit_reg <= {30'h0, stat_reg[idx_reg[1:0] + 2'h1]};
                end
              end
              ST_F3: begin
                if (idx_reg == LAST_CFG) state_reg <= ST_F3_END;
                else idx_reg <= idx_reg + 4'h1;
              end
              default: begin
                state_reg <= ST_F3;
                idx_reg <= 4'h0;
              end
            endcase
          end else if (state_reg == ST_F2) begin
            if (press[K_INC])
              edit_reg <= bump(edit_reg, 3'h0, {2'h0, STAT_HIDDEN});
            if (press[K_CLEAR]) edit_reg <= 32'h0000_0000;
          end else if (state_reg == ST_F3) begin
            if (press[K_DIGIT])
              dpos_reg <= is_scale(idx_reg) ? dpos_reg + 3'h1 : 3'h0;
            if (press[K_INC])
              cfg_edit[idx_reg] <= bump(cfg_edit[idx_reg], dpos_reg,
                                        dig_max(idx_reg));
            if (press[K_CLEAR]) cfg_edit[idx_reg] <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  // operating parameter selection and clearing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      op_select <= 2'h0;
      clear_param <= 1'b0;
    end else begin
      clear_param <= 1'b0;
      if (state_reg == ST_OPER && press[K_NEXT]) begin
        if (stat_reg[(op_select == 2'h2) ? 2'h0 : op_select + 2'h1]
            != STAT_HIDDEN)
          op_select <= (op_select == 2'h2) ? 2'h0 : op_select + 2'h1;
        else if (stat_reg[(op_select == 2'h0) ? 2'h2 : op_select - 2'h1]
                 != STAT_HIDDEN)
          op_select <= (op_select == 2'h0) ? 2'h2 : op_select - 2'h1;
      end
      if (state_reg == ST_OPER && press[K_CLEAR]
          && stat_reg[op_select] < STAT_NOCLR)
        clear_param <= 1'b1;
      if (state_reg == ST_F1 && press[K_CLEAR])
        clear_param <= 1'b1;
    end
  end

  // update period and standstill timers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      upd_reg <= 10'h000;
      sst_reg <= 10'h000;
      update_tick <= 1'b0;
      reading_zero <= 1'b0;
      rate_update <= 1'b0;
    end else begin
      update_tick <= 1'b0;
      reading_zero <= 1'b0;
      rate_update <= 1'b0;
      if (tenth_tick) begin
        if (upd_reg >= upd_tenths(cfg_live[IDX_UPD][3:0]) - 10'h001) begin
          upd_reg <= 10'h000;
          update_tick <= 1'b1;
        end else begin
          upd_reg <= upd_reg + 10'h001;
        end
      end
      if (input_activity || cfg_live[IDX_SST][3:0] >= SST_OFF) begin
        sst_reg <= 10'h000;
      end else if (tenth_tick) begin
        if (sst_reg >= sst_tenths(cfg_live[IDX_SST][3:0],
                                  func_sel == FUNC_RATE) - 10'h001) begin
          sst_reg <= 10'h000;
          reading_zero <= (func_sel != FUNC_RATE);
          rate_update <= (func_sel == FUNC_RATE);
        end else begin
          sst_reg <= sst_reg + 10'h001;
        end
      end
    end
  end

  // display line, value and flashing digit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      disp_line <= 8'h00;
      disp_value <= 32'h0000_0000;
      digit_flash <= 8'h00;
    end else begin
      digit_flash <= in_field || state_reg == ST_CODE
                     || state_reg == ST_CODE_BAD ? 8'h01 << dpos_reg : 8'h00;
      case (state_reg)
        ST_F1: begin
          disp_line <= {4'h0, idx_reg} + 8'h01;
          disp_value <= (idx_reg == 4'h0) ? first_rate_channel
                      : (idx_reg == 4'h1) ? second_rate_channel
                      : derived_result;
        end
        ST_F2: begin
          disp_line <= LINE_STAT_FIRST + {4'h0, idx_reg};
          disp_value <= edit_reg;
        end
        ST_F3: begin
          disp_line <= line_num(idx_reg);
          disp_value <= cfg_edit[idx_reg];
        end
        ST_CODE, ST_CODE_BAD: begin
          disp_line <= 8'h00;
          disp_value <= edit_reg;
        end
        ST_OPER: begin
          disp_line <= 8'h00;
          disp_value <= (op_select == 2'h0) ? first_rate_channel
                      : (op_select == 2'h1) ? second_rate_channel
                      : derived_result;
        end
        default: begin
          disp_line <= 8'h00;
          disp_value <= 32'h0000_0000;
        end
      endcase
    end
  end

  // register port: code write, state and line readback
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      code_reg <= CODE_RESET;
      bus_rdata <= 32'h0000_0000;
    end else begin
      if (bus_wr && bus_addr == OFF_CODE) code_reg <= bus_wdata[15:0];
      bus_rdata <= 32'h0000_0000;
      if (bus_rd) begin
        if (bus_addr == OFF_CODE)
          bus_rdata <= {16'h0000, code_reg};
        else if (bus_addr == OFF_STATE)
          bus_rdata <= {16'h0000, state_reg, idx_reg, 5'h00,
                        op_select, prog_mode};
        else if (bus_addr == OFF_EDIT)
          bus_rdata <= edit_reg;
        else if (bus_addr == OFF_STAT)
          bus_rdata <= {26'h0, stat_reg[2], stat_reg[1], stat_reg[0]};
        else if (bus_addr >= OFF_CFG_BASE && bus_addr < OFF_CFG_END
                 && bus_addr[1:0] == 2'h0)
          bus_rdata <= cfg_live[bus_addr[5:2]];
      end
    end
  end

  // status outputs
  assign prog_mode = (state_reg != ST_OPER);
  assign code_prompt = (state_reg == ST_CODE) || (state_reg == ST_CODE_BAD);
  assign dotted_line = (state_reg == ST_F1_END) || (state_reg == ST_F2_END)
                       || (state_reg == ST_F3_END);
  assign func_sel = cfg_live[IDX_FUNC][2:0];
  assign swap_channels = cfg_live[1][0] && (func_sel <= FUNC_LAST_SWAP);
  assign quad_decode = cfg_live[2][0];
  assign second_slow = cfg_live[2][1];
  assign input_sinking = cfg_live[3][0];
  assign input_level = cfg_live[3][2:1];
  assign first_scale = cfg_live[4];
  assign second_scale = cfg_live[5];
  assign result_scale = cfg_live[6];
  assign retain_readings = (cfg_live[IDX_SST][3:0] == SST_RETAIN);
  assign first_unit = cfg_live[9][1:0];
  assign second_unit = cfg_live[10][1:0];
  assign first_dp = cfg_live[11][1:0];
  assign second_dp = cfg_live[IDX_DP2][1:0];

  logic [1:0] edit_low, idx_low;
  logic [2:0] edit_func;
  // plain copies for sampled-value use in checks
  assign edit_low = edit_reg[1:0];
  assign idx_low = idx_reg[1:0];
  assign edit_func = cfg_edit[IDX_FUNC][2:0];

  code_entry_a: assert property (@(posedge clk) disable iff (reset)
    state_reg == ST_OPER && press[K_MODE] |=> state_reg == ST_CODE)
    else $error("mode key did not open code prompt");
  bad_code_a: assert property (@(posedge clk) disable iff (reset)
    state_reg == ST_CODE && next_go && !code_ok && !press[K_MODE]
    |=> state_reg == ST_CODE_BAD && code_prompt)
    else $error("wrong code not refused");
  code_time_a: assert property (@(posedge clk) disable iff (reset)
    state_reg == ST_CODE_BAD |-> tmo_reg < CODE_TMO_TENTHS)
    else $error("code fallback overran");
  no_code_a: assert property (@(posedge clk) disable iff (reset)
    state_reg == ST_CODE && next_go && code_reg == CODE_RESET
    && !press[K_MODE] |=> state_reg == ST_F1 && idx_reg == 4'h0)
    else $error("empty code not accepted");
  field_order_a: assert property (@(posedge clk) disable iff (reset)
    state_reg == ST_F1_END && next_go && !press[K_MODE]
    |=> state_reg == ST_F2 && idx_reg == 4'h0)
    else $error("field two not entered");
  dots_shown_a: assert property (@(posedge clk) disable iff (reset)
    state_reg == ST_F1 && idx_reg == 4'h2 && next_go && !press[K_MODE]
    |=> dotted_line ##1 disp_line == 8'h00)
    else $error("dotted line missing after field one");
  stat_commit_a: assert property (@(posedge clk) disable iff (reset)
    state_reg == ST_F2 && next_go && !press[K_MODE]
    |=> stat_reg[$past(idx_low)] == $past(edit_low))
    else $error("status not stored on advance");
  hidden_skip_a: assert property (@(posedge clk) disable iff (reset)
    state_reg == ST_OPER && press[K_NEXT] && stat_reg[op_select] != 2'h2
    |=> stat_reg[op_select] != STAT_HIDDEN)
    else $error("hidden parameter selected");
  cfg_hold_a: assert property (@(posedge clk) disable iff (reset)
    state_reg == ST_F3 && !press[K_MODE] |=> $stable(func_sel))
    else $error("field three committed early");
  commit_a: assert property (@(posedge clk) disable iff (reset)
    state_reg == ST_F3 && press[K_MODE]
    |=> state_reg == ST_OPER && func_sel == $past(edit_func))
    else $error("field three not committed on exit");
endmodule : kpm_menu

// ### src/kpm_pkg.sv
package kpm_pkg;
  // clocking and tick timing
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_PERIOD_US;
  localparam int TENTH_MS = 100;
  localparam logic [6:0] TICKS_PER_TENTH = 7'(TENTH_MS * 1000 / TICK_PERIOD_US);
  localparam int CODE_TMO_S = 15;
  localparam logic [9:0] CODE_TMO_TENTHS = 10'(CODE_TMO_S * 10);
  localparam int REP_DELAY_MS = 500;
  localparam logic [3:0] REP_DELAY_TENTHS = 4'(REP_DELAY_MS / TENTH_MS);
  // key bit positions
  localparam int K_MODE = 0;
  localparam int K_NEXT = 1;
  localparam int K_DIGIT = 2;
  localparam int K_INC = 3;
  localparam int K_CLEAR = 4;
  // programming lines
  localparam int NCFG = 13;
  localparam logic [3:0] LAST_CFG = 4'd12;
  localparam logic [7:0] LINE_F3_FIRST = 8'd21;
  localparam logic [7:0] LINE_DP_BASE = 8'd25;
  localparam logic [7:0] LINE_STAT_FIRST = 8'd11;
  localparam logic [3:0] IDX_FUNC = 4'd0;
  localparam logic [3:0] IDX_DP2 = 4'd12;
  localparam logic [3:0] FIRST_SCALE = 4'd4;
  localparam logic [3:0] LAST_SCALE = 4'd6;
  localparam logic [3:0] IDX_UPD = 4'd7;
  localparam logic [3:0] IDX_SST = 4'd8;
  localparam logic [1:0] STAT_HIDDEN = 2'd2;
  localparam logic [1:0] STAT_NOCLR = 2'd1;
  localparam logic [2:0] FUNC_RATE = 3'd7;
  localparam logic [2:0] FUNC_LAST_SWAP = 3'd2;
  localparam logic [3:0] SST_OFF = 4'd8;
  localparam logic [3:0] SST_RETAIN = 4'd9;
  localparam logic [31:0] SCALE_ONE = 32'h0001_0000;
  localparam logic [31:0] SCALE_MIN = 32'h0000_0001;
  localparam logic [3:0] UPD_DEFAULT = 4'd1;
  localparam logic [2:0] CODE_DIGITS_LAST = 3'd3;
  // register offsets
  localparam logic [7:0] OFF_CODE = 8'h00;
  localparam logic [7:0] OFF_STATE = 8'h04;
  localparam logic [7:0] OFF_EDIT = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_CFG_BASE = 8'h40;
  localparam logic [7:0] OFF_CFG_END = 8'h74;
  localparam logic [15:0] CODE_RESET = 16'h0000;

  typedef enum logic [3:0] {
    ST_OPER, ST_CODE, ST_CODE_BAD, ST_F1, ST_F1_END,
    ST_F2, ST_F2_END, ST_F3, ST_F3_END
  } kpm_state_e;

  // displayed line number of a field-three index
  function automatic logic [7:0] line_num(input logic [3:0] i);
    return (i < 4'd11) ? LINE_F3_FIRST + {4'd0, i}
                       : LINE_DP_BASE + {4'd0, i};
  endfunction : line_num

  function automatic logic is_scale(input logic [3:0] i);
    return (i >= FIRST_SCALE) && (i <= LAST_SCALE);
  endfunction : is_scale

  // highest digit value per line
  function automatic logic [3:0] dig_max(input logic [3:0] i);
    case (i)
      4'd0: return 4'd7;
      4'd1: return 4'd1;
      4'd2: return 4'd3;
      4'd3: return 4'd5;
      4'd7: return 4'd8;
      4'd8: return 4'd9;
      4'd9, 4'd10: return 4'd2;
      4'd11, 4'd12: return 4'd3;
      default: return 4'd9;
    endcase
  endfunction : dig_max

  function automatic logic [31:0] cfg_default(input logic [3:0] i);
    if (is_scale(i)) return SCALE_ONE;
    if (i == IDX_UPD) return {28'd0, UPD_DEFAULT};
    return 32'h0000_0000;
  endfunction : cfg_default

  // raise one bcd digit, stopping at its maximum
  function automatic logic [31:0] bump(input logic [31:0] v,
                                       input logic [2:0] p,
                                       input logic [3:0] mx);
    logic [31:0] r;
    logic [3:0] d;
    r = v;
    d = v[{p, 2'b00} +: 4];
    if (d < mx) r[{p, 2'b00} +: 4] = d + 4'd1;
    return r;
  endfunction : bump

  // display update period in tenths of a second
  function automatic logic [9:0] upd_tenths(input logic [3:0] c);
    case (c)
      4'd0: return 10'd5;
      4'd1: return 10'd10;
      4'd2: return 10'd20;
      4'd3: return 10'd30;
      4'd4: return 10'd50;
      4'd5: return 10'd100;
      4'd6: return 10'd200;
      4'd7: return 10'd300;
      default: return 10'd600;
    endcase
  endfunction : upd_tenths

  // standstill time in tenths; pulse-rate mode is ten times shorter
  function automatic logic [9:0] sst_tenths(input logic [3:0] c,
                                            input logic rate);
    logic [9:0] t;
    case (c)
      4'd0: t = 10'd1;
      4'd1: t = 10'd2;
      4'd2: t = 10'd3;
      4'd3: t = 10'd5;
      4'd4: t = 10'd10;
      4'd5: t = 10'd20;
      4'd6: t = 10'd30;
      default: t = 10'd60;
    endcase
    return rate ? t : 10'(t * 10'd10);
  endfunction : sst_tenths
endpackage : kpm_pkg

// ### test/kpm_keypad.sv
`timescale 1ns/100ps
// operator keypad: holds each requested key long enough to pass debounce
module kpm_keypad #(
  parameter int HOLD = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [4:0] press,
  output logic [4:0] keys_reg
);
  logic [7:0] hold_reg;

  // latch a request, hold it, then let every key go
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      keys_reg <= 5'h00;
      hold_reg <= 8'h00;
    end else if (press != 5'h00) begin
      keys_reg <= press;
      hold_reg <= 8'(HOLD);
    end else if (hold_reg != 8'h00) begin
      hold_reg <= hold_reg - 8'h01;
    end else begin
      keys_reg <= 5'h00;
    end
  end
endmodule : kpm_keypad

// ### test/kpm_menu_tb_top.sv
`timescale 1ns/100ps
module kpm_menu_tb_top import kpm_pkg::*;;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] press = 5'h00;
  logic [4:0] keys;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0000_0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [31:0] bus_rdata, first_scale, second_scale, result_scale;
  logic [31:0] disp_value;
  logic prog_mode, code_prompt, dotted_line;
  logic update_tick, reading_zero, clear_param;
  logic [7:0] disp_line, digit_flash;
  logic [2:0] func_sel;
  logic [1:0] first_dp, op_select;
  int n_upd = 0, n_zero = 0, n_clr = 0, u0 = 0, z0 = 0;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;

  kpm_keypad i_pad (.clk(clk), .reset(reset), .press(press), .keys_reg(keys));
  kpm_menu #(.TICK_LEN(4)) i_dut (.clk(clk), .reset(reset),
    .key_mode(keys[0]), .key_next(keys[1]), .key_digit(keys[2]),
    .key_inc(keys[3]), .key_clear(keys[4]),
    .first_rate_channel(32'h0000_0012), .second_rate_channel(32'h0000_0034),
    .derived_result(32'h0000_0056), .input_activity(1'b0),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .prog_mode(prog_mode),
    .code_prompt(code_prompt), .dotted_line(dotted_line),
    .disp_line(disp_line), .disp_value(disp_value),
    .digit_flash(digit_flash), .op_select(op_select),
    .clear_param(clear_param), .reading_zero(reading_zero),
    .rate_update(), .update_tick(update_tick),
    .retain_readings(), .func_sel(func_sel), .swap_channels(),
    .quad_decode(), .second_slow(), .input_sinking(), .input_level(),
    .first_scale(first_scale), .second_scale(second_scale),
    .result_scale(result_scale), .first_unit(), .second_unit(),
    .first_dp(first_dp), .second_dp());

  // clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // one key press through the keypad model, then a settle gap
  task automatic hit(input int k);
    press <= 5'(1 << k);
    @(posedge clk);
    press <= 5'h00;
    repeat (40) @(posedge clk);
  endtask : hit

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(posedge clk);
    cmp(bus_rdata, exp);
  endtask : rd

  // count one-cycle pulses of the timers and the clear output
  always @(posedge clk) begin
    if (update_tick) n_upd <= n_upd + 1;
    if (reading_zero) n_zero <= n_zero + 1;
    if (clear_param) n_clr <= n_clr + 1;
  end

  // main sequence: defaults, field walk, commits, operating keys, fall-back
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    cmp(first_scale, SCALE_ONE);
    cmp(second_scale, SCALE_ONE);
    cmp(result_scale, SCALE_ONE);
    cmp(32'(func_sel), 32'h0000_0000);
    cmp(32'(first_dp), 32'h0000_0000);
    rd(OFF_CFG_BASE + 8'h1C, 32'h0000_0001);
    rd(OFF_STAT, 32'h0000_0000);
    hit(K_MODE);
    cmp(32'(prog_mode & code_prompt), 32'h0000_0001);
    hit(K_DIGIT);
    cmp(32'(digit_flash), 32'h0000_0002);
    hit(K_NEXT);
    cmp(32'(disp_line), 32'h0000_0001);
    cmp(disp_value, 32'h0000_0012);
    cmp(32'(digit_flash), 32'h0000_0001);
    hit(K_NEXT);
    cmp(32'(disp_line), 32'h0000_0002);
    hit(K_NEXT);
    cmp(32'(disp_line), 32'h0000_0003);
    hit(K_NEXT);
    cmp(32'(dotted_line), 32'h0000_0001);
    hit(K_NEXT);
    cmp(32'(disp_line), 32'h0000_000B);
    hit(K_INC);
    hit(K_NEXT);
    rd(OFF_STAT, 32'h0000_0001);
    cmp(32'(disp_line), 32'h0000_000C);
    hit(K_INC);
    hit(K_INC);
    hit(K_NEXT);
    rd(OFF_STAT, 32'h0000_0009);
    hit(K_NEXT);
    cmp(32'(dotted_line), 32'h0000_0001);
    hit(K_NEXT);
    cmp(32'(disp_line), 32'(LINE_F3_FIRST));
    hit(K_INC);
    rd(OFF_CFG_BASE, 32'h0000_0000);
    hit(K_MODE);
    cmp(32'(func_sel), 32'h0000_0001);
    cmp(32'(prog_mode), 32'h0000_0000);
    hit(K_CLEAR);
    hit(K_NEXT);
    cmp(32'(op_select), 32'h0000_0002);
    cmp(disp_value, 32'h0000_0056);
    hit(K_CLEAR);
    cmp(32'(n_clr), 32'h0000_0001);
    wr(OFF_CODE, 32'h0000_0001);
    hit(K_MODE);
    hit(K_NEXT);
    cmp(32'(code_prompt), 32'h0000_0001);
    repeat (18000) @(posedge clk);
    u0 = n_upd;
    z0 = n_zero;
    repeat (40000) @(posedge clk);
    cmp(32'(n_upd - u0), 32'h0000_000A);
    cmp(32'(n_zero - z0), 32'h0000_000A);
    cmp(32'(prog_mode), 32'h0000_0001);
    repeat (3000) @(posedge clk);
    cmp(32'(prog_mode), 32'h0000_0000);
    report_and_stop();
  end
endmodule : kpm_menu_tb_top
